// File: core/pml_pkg.sv
package pml_pkg;
    // ---------------------------------------------------------------
    // sizes of the macrocell section
    // ---------------------------------------------------------------
    localparam int N_CELL = 16;  // output cells, two groups
    localparam int N_GRP = 8;  // cells per group
    localparam int N_PIN = 24;  // ports a, b, c
    localparam int N_PT = 137;  // product-term capacity of the and array
    localparam int AB_NAT = 3;  // native terms, ab cells
    localparam int BC_NAT = 4;  // native terms, bc cells
    localparam int AB_BOR = 6;  // borrow limit, ab cells
    localparam int BC_LO_BOR = 5;  // borrow limit, bc cells 0-3
    localparam int BC_HI_BOR = 6;  // borrow limit, bc cells 4-7
    localparam int BOR_W = 6;  // width of one borrow enable field
    localparam int BC_BASE = N_GRP * AB_NAT;  // first bc sum term
    localparam int SUM_W = BC_BASE + N_GRP * BC_NAT;  // sum-term pool
    localparam int N_CS = 3;  // port d chip selects
    localparam int NIB = 4;  // input cells per gate term
    localparam int N_GATE = N_PIN / NIB;  // gate terms
    localparam int FF_W = 4;  // width of the flip-flop type code
    localparam int IN_W = 3;  // width of the input cell mode code
    // ---------------------------------------------------------------
    // synchronised bus vector layout
    // ---------------------------------------------------------------
    localparam int B_RD = 8;  // read strobe bit, data below it
    localparam int B_WR = 9;  // write strobe bit
    localparam int B_SEL = 10;  // first select bit
    localparam int N_SEL = 7;
    localparam int BUS_W = B_SEL + N_SEL;
    localparam int SEL_CELL_AB = 0;
    localparam int SEL_CELL_BC = 1;
    localparam int SEL_MASK_AB = 2;
    localparam int SEL_MASK_BC = 3;
    localparam int SEL_IN_A = 4;
    localparam int SEL_IN_B = 5;
    localparam int SEL_IN_C = 6;
    localparam logic [7:0] MASK_RST = 8'h00;  // write masks after reset
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [3:0] {FF_D = 4'b0001, FF_T = 4'b0010, FF_JK = 4'b0100, FF_SR = 4'b1000} pml_ff_t;
    typedef enum logic [2:0] {IN_PASS = 3'b001, IN_LATCH = 3'b010, IN_REG = 3'b100} pml_in_t;
    // ---------------------------------------------------------------
    // product-term allocation arithmetic
    // ---------------------------------------------------------------
    function automatic int nat_of(input int c);
        return (c < N_GRP) ? AB_NAT : BC_NAT;
    endfunction
    function automatic int bor_of(input int c);
        return (c < N_GRP) ? AB_BOR : ((c % N_GRP) < NIB ? BC_LO_BOR : BC_HI_BOR);
    endfunction
    function automatic int base_of(input int c);
        return (c < N_GRP) ? 0 : BC_BASE;
    endfunction
    // native term k of cell c
    function automatic int nat_idx(input int c, input int k);
        return base_of(c) + (c % N_GRP) * nat_of(c) + k;
    endfunction
    // borrow candidate b of cell c: natives of the next two cells in its group
    function automatic int cand_idx(input int c, input int b);
        int n;
        int donor;
        n = nat_of(c);
        donor = ((c % N_GRP) + 1 + b / n) % N_GRP;
        return base_of(c) + donor * n + b % n;
    endfunction
endpackage

// File: core/pml_out_cell.sv
`timescale 1ns/1ps
module pml_out_cell
    import pml_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_q_n,
    input wire logic sum_in,
    input wire logic aux_in,
    input wire logic pol,
    input wire pml_ff_t ff_type,
    input wire logic reg_sel,
    input wire logic clk_en,
    input wire logic pre,
    input wire logic clr,
    input wire logic ld_en,
    input wire logic ld_val,
    output logic q_r,
    output logic y
);
    logic d;  // sum after the polarity stage
    logic q_nxt;

    // ---------------------------------------------------------------
    // next state: load beats clear, clear beats preset, then clock
    // ---------------------------------------------------------------
    always_comb
    begin
        d = sum_in ^ pol;
        q_nxt = q_r;
        if (ld_en)
        begin
            q_nxt = ld_val;
        end
        else if (clr)
        begin
            q_nxt = 1'b0;
        end
        else if (pre)
        begin
            q_nxt = 1'b1;
        end
        else if (clk_en)
        begin
            case (ff_type)
                FF_D: q_nxt = d;
                FF_T: q_nxt = q_r ^ d;
                FF_JK: q_nxt = (d & ~aux_in) | (d & aux_in & ~q_r) | (~d & ~aux_in & q_r);
                FF_SR: q_nxt = d | (~aux_in & q_r);
                default: q_nxt = q_r;
            endcase
        end
        y = reg_sel ? q_r : d;
    end

    always_ff @(posedge ref_clk or negedge rst_q_n)
    begin
        if (!rst_q_n)
        begin
            q_r <= 1'b0;
        end
        else
        begin
            q_r <= q_nxt;
        end
    end

    a_load_wins: assert property (@(posedge ref_clk) disable iff (!rst_q_n) ld_en |=> q_r == $past(ld_val))
        else $error("cell load did not override preset, clear or clock");
    a_clear_first: assert property (@(posedge ref_clk) disable iff (!rst_q_n) (clr && !ld_en) |=> !q_r)
        else $error("cell clear did not force zero");
endmodule

// File: core/pml_macrocells.sv
`timescale 1ns/1ps
// Operation
// - three port d selects, no cells used
// - 24 input cells, 16 output cells
// - ab/bc groups; cell n on data bit n
// - native and borrowable term counts per cell
// - a used term cannot be borrowed
// - xor polarity, register/comb mux, feedback
// - flip-flop acts as d, t, jk, sr
// - clock from term or external, rising
// - preset/clear active high; clear two terms
// - processor load overrides preset, clear, clock
// - edge or level loading by configuration
// - per-group write mask, reset zero
// - processor reads output and input cells
// - pin enable is term or direction
// - undefined enable output pin drives from reset
// - internal node frees pin, keeps feedback
// - input cell latches, registers or passes
// - gate from term or strobe, per nibble
// - strobe-clocked cells capture upper address bits
// - and array holds up to 137 terms
// - expansion consumes a cell, adds delay
// - mailbox through port a data-out and inputs
module pml_macrocells
    import pml_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] mcu_data_in,
    input wire logic mcu_wr_n,
    input wire logic mcu_rd_n,
    input wire logic [N_SEL-1:0] config_io_space_sel,
    input wire logic addr_latch_strobe,
    input wire logic ext_clock_input,
    input wire logic [N_PIN-1:0] port_pin_in,
    input wire logic [SUM_W-1:0] sum_terms,
    input wire logic [N_CELL-1:0] pt_aux,
    input wire logic [N_CELL-1:0] pt_clk,
    input wire logic [N_CELL-1:0] pt_pre,
    input wire logic [N_CELL-1:0] pt_clr_a,
    input wire logic [N_CELL-1:0] pt_clr_b,
    input wire logic [N_PIN-1:0] pt_oe,
    input wire logic [N_GATE-1:0] pt_gate,
    input wire logic [N_CS-1:0] pt_cs,
    input wire logic [N_CELL-1:0] cfg_pol,
    input wire logic [N_CELL-1:0] cfg_reg,
    input wire logic [N_CELL*FF_W-1:0] cfg_ff_type,
    input wire logic [N_CELL-1:0] cfg_clk_ext,
    input wire logic [N_CELL-1:0] cfg_node,
    input wire logic [N_CELL-1:0] cfg_to_alt,
    input wire logic [N_CELL*BOR_W-1:0] cfg_borrow,
    input wire logic [N_CELL-1:0] cfg_expand,
    input wire logic cfg_level_load,
    input wire logic [N_PIN*IN_W-1:0] cfg_in_mode,
    input wire logic [N_GATE-1:0] cfg_gate_strobe,
    input wire logic [N_PIN-1:0] cfg_oe_eq,
    input wire logic [N_PIN-1:0] port_dir,
    input wire logic [N_PIN-1:0] port_dout,
    output logic [N_PIN-1:0] port_out_r,
    output logic [N_PIN-1:0] port_oe_r,
    output logic [N_PIN-1:0] logic_in_bus_r,
    output logic [N_CELL-1:0] cell_fb_r,
    output logic [7:0] mcu_data_out_r,
    output logic mcu_data_oe_r,
    output logic [N_CS-1:0] chip_sel_d_r
);
    // ---------------------------------------------------------------
    // reset release and pin synchronisers
    // ---------------------------------------------------------------
    logic rst_s1_r;
    logic rst_q;  // released reset used everywhere below
    localparam int PIN_W = BUS_W + 2 + N_PIN;  // bus, strobe, clock, port pins
    // strobe bits of the chains reset to their idle high level, so no false write edge follows reset
    localparam logic [PIN_W-1:0] PIN_IDLE = (PIN_W'(1) << (N_PIN + 2 + B_WR)) | (PIN_W'(1) << (N_PIN + 2 + B_RD));
    logic [PIN_W-1:0] s1_r;  // first stage, read only by s2_r
    logic [PIN_W-1:0] s2_r;
    logic [PIN_W-1:0] s3_r;
    logic [PIN_W-1:0] pin_raw;
    logic [BUS_W-1:0] bus_s;  // accepted bus value
    logic [N_PIN-1:0] pins_s;  // accepted port pin values
    logic strobe_s;
    logic ext_rise;  // second stage high while third still low

    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rst_s1_r <= 1'b0;
            rst_q <= 1'b0;
        end
        else
        begin
            rst_s1_r <= 1'b1;
            rst_q <= rst_s1_r;
        end
    end

    // strobes idle high so the write detector sees no false edge
    always_comb
    begin
        pin_raw = {config_io_space_sel, mcu_wr_n, mcu_rd_n, mcu_data_in, addr_latch_strobe, ext_clock_input,
            port_pin_in};
        bus_s = s3_r[PIN_W-1 -: BUS_W];
        strobe_s = s3_r[N_PIN+1];
        pins_s = s3_r[N_PIN-1:0];
        ext_rise = s2_r[N_PIN] & ~s3_r[N_PIN];
    end

    always_ff @(posedge ref_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            s1_r <= PIN_IDLE;
            s2_r <= PIN_IDLE;
            s3_r <= PIN_IDLE;
        end
        else
        begin
            s1_r <= pin_raw;
            s2_r <= s1_r;
            s3_r <= s2_r;
        end
    end

    // ---------------------------------------------------------------
    // processor write path and masks
    // ---------------------------------------------------------------
    logic wr_act;
    logic rd_act;
    logic wr_prev_r;
    logic [7:0] cap_r;  // data held for edge loading
    logic [7:0] cap_nxt;
    logic [N_SEL-1:0] sel_cap_r;
    logic [N_SEL-1:0] sel_cap_nxt;
    logic [7:0] mask_ab_r;
    logic [7:0] mask_ab_nxt;
    logic [7:0] mask_bc_r;
    logic [7:0] mask_bc_nxt;
    logic load_go;  // a load happens this cycle
    logic [7:0] ld_data;
    logic [N_SEL-1:0] ld_sel;
    logic [N_CELL-1:0] ld_vec;
    logic trail;

    always_comb
    begin
        wr_act = ~bus_s[B_WR];
        rd_act = ~bus_s[B_RD];
        trail = wr_prev_r & ~wr_act;
        cap_nxt = wr_act ? bus_s[7:0] : cap_r;
        sel_cap_nxt = wr_act ? bus_s[B_SEL +: N_SEL] : sel_cap_r;
        // level mode loads every active cycle, edge mode only at the trailing edge
        if (cfg_level_load)
        begin
            load_go = wr_act;
            ld_data = bus_s[7:0];
            ld_sel = bus_s[B_SEL +: N_SEL];
        end
        else
        begin
            load_go = trail;
            ld_data = cap_r;
            ld_sel = sel_cap_r;
        end
        ld_vec[N_GRP-1:0] = (load_go && ld_sel[SEL_CELL_AB]) ? ~mask_ab_r : BYTE_ZERO;
        ld_vec[N_CELL-1:N_GRP] = (load_go && ld_sel[SEL_CELL_BC]) ? ~mask_bc_r : BYTE_ZERO;
        // masks take a value once per write, at its trailing edge
        mask_ab_nxt = (trail && sel_cap_r[SEL_MASK_AB]) ? cap_r : mask_ab_r;
        mask_bc_nxt = (trail && sel_cap_r[SEL_MASK_BC]) ? cap_r : mask_bc_r;
    end

    always_ff @(posedge ref_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            wr_prev_r <= 1'b0;
            cap_r <= BYTE_ZERO;
            sel_cap_r <= '0;
            mask_ab_r <= MASK_RST;
            mask_bc_r <= MASK_RST;
        end
        else
        begin
            wr_prev_r <= wr_act;
            cap_r <= cap_nxt;
            sel_cap_r <= sel_cap_nxt;
            mask_ab_r <= mask_ab_nxt;
            mask_bc_r <= mask_bc_nxt;
        end
    end

    // ---------------------------------------------------------------
    // product-term allocation and output cells
    // ---------------------------------------------------------------
    logic [N_CELL-1:0] sum_full;  // or of native, borrowed and expanded terms
    logic [N_CELL-1:0] consumed;  // cells used up by expansion
    logic [N_CELL-1:0] exp_r;  // one-cycle delayed sums for expansion
    logic [N_CELL-1:0] pt_prev_r;
    logic [N_CELL-1:0] cell_q;
    logic [N_CELL-1:0] cell_y;
    logic [N_CELL-1:0] cell_clk_en;
    logic [SUM_W-1:0] taken;  // terms already claimed by a borrower

    // terms come from the external and array; the pool is SUM_W terms wide, N_PT is not applied
    always_comb
    begin
        taken = '0;
        sum_full = '0;
        consumed = '0;
        for (int c = 0; c < N_CELL; c++)
        begin
            for (int b = 0; b < BOR_W; b++)
            begin
                // a term is granted once; later borrowers see it as taken
                if (b < bor_of(c) && cfg_borrow[c*BOR_W+b] && !taken[cand_idx(c, b)])
                begin
                    taken[cand_idx(c, b)] = 1'b1;
                    sum_full[c] = sum_full[c] | sum_terms[cand_idx(c, b)];
                end
            end
        end
        for (int c = 0; c < N_CELL; c++)
        begin
            for (int k = 0; k < BC_NAT; k++)
            begin
                if (k < nat_of(c) && !taken[nat_idx(c, k)])
                begin
                    sum_full[c] = sum_full[c] | sum_terms[nat_idx(c, k)];
                end
            end
            // expansion takes the next cell's sum a cycle late
            if (cfg_expand[c])
            begin
                sum_full[c] = sum_full[c] | exp_r[base_of(c)/AB_NAT + (c % N_GRP + 1) % N_GRP];
                consumed[base_of(c)/AB_NAT + (c % N_GRP + 1) % N_GRP] = 1'b1;
            end
        end
        cell_clk_en = (cfg_clk_ext & {N_CELL{ext_rise}}) | (~cfg_clk_ext & pt_clk & ~pt_prev_r);
    end

    always_ff @(posedge ref_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            exp_r <= '0;
            pt_prev_r <= '0;
        end
        else
        begin
            exp_r <= sum_full;
            pt_prev_r <= pt_clk;
        end
    end

    for (genvar c = 0; c < N_CELL; c++)
    begin : g_cell
        pml_out_cell u_cell (
            .ref_clk(ref_clk),
            .rst_q_n(rst_q),
            .sum_in(sum_full[c]),
            .aux_in(pt_aux[c]),
            .pol(cfg_pol[c]),
            .ff_type(pml_ff_t'(cfg_ff_type[c*FF_W +: FF_W])),
            .reg_sel(cfg_reg[c]),
            .clk_en(cell_clk_en[c]),
            .pre(pt_pre[c]),
            .clr(pt_clr_a[c] | pt_clr_b[c]),
            .ld_en(ld_vec[c]),
            .ld_val(ld_data[c % N_GRP]),
            .q_r(cell_q[c]),
            .y(cell_y[c])
        );
    end

    // ---------------------------------------------------------------
    // pin drive, input cells, read-back
    // ---------------------------------------------------------------
    logic [N_PIN-1:0] routed;  // pin owned by a cell
    logic [N_PIN-1:0] cell_val;
    logic [N_PIN-1:0] port_out_nxt;
    logic [N_PIN-1:0] port_oe_nxt;
    logic [N_PIN-1:0] in_val_r;
    logic [N_PIN-1:0] in_val_nxt;
    logic [N_GATE-1:0] gate;
    logic [N_GATE-1:0] gate_prev_r;
    logic [7:0] rd_nxt;
    logic rd_oe_nxt;
    logic [N_CELL-1:0] drives;

    always_comb
    begin
        // a node or a consumed cell leaves its pin to the data-out register
        drives = ~cfg_node & ~consumed;
        routed = '0;
        cell_val = '0;
        for (int n = 0; n < N_GRP; n++)
        begin
            // ab cell on a or b, bc cell on b or c; ab wins a shared b pin
            if (drives[N_GRP+n] && cfg_to_alt[N_GRP+n])
            begin
                routed[2*N_GRP+n] = 1'b1;
                cell_val[2*N_GRP+n] = cell_y[N_GRP+n];
            end
            else if (drives[N_GRP+n])
            begin
                routed[N_GRP+n] = 1'b1;
                cell_val[N_GRP+n] = cell_y[N_GRP+n];
            end
            if (drives[n] && cfg_to_alt[n])
            begin
                routed[N_GRP+n] = 1'b1;
                cell_val[N_GRP+n] = cell_y[n];
            end
            else if (drives[n])
            begin
                routed[n] = 1'b1;
                cell_val[n] = cell_y[n];
            end
        end
        // unrouted pins on ports a, b and c carry the master's data-out value
        port_out_nxt = (routed & cell_val) | (~routed & port_dout);
        port_oe_nxt = pt_oe | port_dir | (routed & ~cfg_oe_eq);
        // gate per nibble: term or address strobe
        gate = (cfg_gate_strobe & {N_GATE{strobe_s}}) | (~cfg_gate_strobe & pt_gate);
        for (int p = 0; p < N_PIN; p++)
        begin
            case (pml_in_t'(cfg_in_mode[p*IN_W +: IN_W]))
                IN_PASS: in_val_nxt[p] = pins_s[p];
                IN_LATCH: in_val_nxt[p] = gate[p/NIB] ? pins_s[p] : in_val_r[p];
                IN_REG: in_val_nxt[p] = (gate[p/NIB] && !gate_prev_r[p/NIB]) ? pins_s[p] : in_val_r[p];
                default: in_val_nxt[p] = pins_s[p];
            endcase
        end
        // read decode; the slave's input-cell writes reach the master here
        rd_nxt = BYTE_ZERO;
        rd_oe_nxt = rd_act;
        if (bus_s[B_SEL+SEL_CELL_AB])
        begin
            rd_nxt = cell_q[N_GRP-1:0];
        end
        else if (bus_s[B_SEL+SEL_CELL_BC])
        begin
            rd_nxt = cell_q[N_CELL-1:N_GRP];
        end
        else if (bus_s[B_SEL+SEL_MASK_AB])
        begin
            rd_nxt = mask_ab_r;
        end
        else if (bus_s[B_SEL+SEL_MASK_BC])
        begin
            rd_nxt = mask_bc_r;
        end
        else if (bus_s[B_SEL+SEL_IN_A])
        begin
            rd_nxt = in_val_r[N_GRP-1:0];
        end
        else if (bus_s[B_SEL+SEL_IN_B])
        begin
            rd_nxt = in_val_r[2*N_GRP-1:N_GRP];
        end
        else if (bus_s[B_SEL+SEL_IN_C])
        begin
            rd_nxt = in_val_r[N_PIN-1:2*N_GRP];
        end
        else
        begin
            rd_oe_nxt = 1'b0;  // nothing of ours selected: bus left alone
        end
        if (!rd_act)
        begin
            rd_nxt = BYTE_ZERO;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_q)
    begin
        if (!rst_q)
        begin
            port_out_r <= '0;
            port_oe_r <= '0;
            in_val_r <= '0;
            gate_prev_r <= '0;
            logic_in_bus_r <= '0;
            cell_fb_r <= '0;
            mcu_data_out_r <= BYTE_ZERO;
            mcu_data_oe_r <= 1'b0;
            chip_sel_d_r <= '0;
        end
        else
        begin
            port_out_r <= port_out_nxt;
            port_oe_r <= port_oe_nxt;
            in_val_r <= in_val_nxt;
            gate_prev_r <= gate;
            logic_in_bus_r <= in_val_nxt;
            cell_fb_r <= cell_y;
            mcu_data_out_r <= rd_nxt;
            mcu_data_oe_r <= rd_oe_nxt;
            chip_sel_d_r <= pt_cs;
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_mask_blocks: assert property (@(posedge ref_clk) disable iff (!rst_q) (ld_vec[N_GRP-1:0] & mask_ab_r) == 0)
        else $error("masked ab cell was loaded");
    a_oe_dir: assert property (@(posedge ref_clk) disable iff (!rst_q) rst_q |=> (port_oe_r & $past(port_dir)) == $past(port_dir))
        else $error("direction register did not enable pin");
    a_cs_follow: assert property (@(posedge ref_clk) disable iff (!rst_q) rst_q |=> chip_sel_d_r == $past(pt_cs))
        else $error("chip select did not follow its term");
    a_pass_in: assert property (@(posedge ref_clk) disable iff (!rst_q) (cfg_in_mode[IN_W-1:0] == IN_PASS) |=> logic_in_bus_r[0] == $past(pins_s[0]))
        else $error("pass-through input cell did not follow pin");
    a_level_load: assert property (@(posedge ref_clk) disable iff (!rst_q) (cfg_level_load && wr_act && bus_s[B_SEL+SEL_CELL_AB] && !mask_ab_r[0]) |=> cell_q[0] == $past(bus_s[0]))
        else $error("level load missed cell 0");
    a_edge_load: assert property (@(posedge ref_clk) disable iff (!rst_q) (!cfg_level_load && wr_act) ##1 (!cfg_level_load && !wr_act && sel_cap_r[SEL_CELL_AB] && !mask_ab_r[N_GRP-1]) |=> cell_q[N_GRP-1] == $past(cap_r[N_GRP-1]))
        else $error("edge load missed top ab cell");
    a_read_ab: assert property (@(posedge ref_clk) disable iff (!rst_q) (rd_act && bus_s[B_SEL+SEL_CELL_AB]) |=> mcu_data_oe_r && mcu_data_out_r == $past(cell_q[N_GRP-1:0]))
        else $error("ab cells not read back");
    a_node_free: assert property (@(posedge ref_clk) disable iff (!rst_q) (cfg_node[0] && !cfg_to_alt[0]) |=> port_out_r[0] == $past(port_dout[0]))
        else $error("node cell still drove its pin");
endmodule

// File: tb/pml_mcu_model.sv
`timescale 1ns/1ps
// --------------------------------------------------------------
// processor on the shared data bus
// --------------------------------------------------------------
module pml_mcu_model
    import pml_pkg::*;
(
    input wire logic ref_clk,
    input wire logic [7:0] rd_data,
    output logic wr_n,
    output logic rd_n,
    output logic [N_SEL-1:0] sel,
    output logic [7:0] data
);
    // strobes idle high; a released data bus shows the inverse byte
    initial
    begin
        wr_n = 1'b1;
        rd_n = 1'b1;
        sel = '0;
        data = 8'h00;
    end
    // write strobe low 5 cycles, then high long enough for an edge load
    task automatic write_byte(input int s, input logic [7:0] d);
        @(posedge ref_clk);
        sel <= N_SEL'(1) << s;
        data <= d;
        wr_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        wr_n <= 1'b1;
        repeat (12) @(posedge ref_clk);
        sel <= '0;
        data <= ~d;
    endtask
    // read data is taken while the strobe is still low
    task automatic read_byte(input int s, output logic [7:0] got);
        @(posedge ref_clk);
        sel <= N_SEL'(1) << s;
        rd_n <= 1'b0;
        repeat (7) @(posedge ref_clk);
        got = rd_data;
        rd_n <= 1'b1;
        sel <= '0;
        repeat (6) @(posedge ref_clk);
    endtask
endmodule

// File: tb/pml_macrocells_tb_top.sv
`timescale 1ns/1ps
module pml_macrocells_tb_top
    import pml_pkg::*;
;
    logic ref_clk = 1'b0;
    logic rst_n = 1'b0;
    logic [N_PIN-1:0] pins = 24'h00_003C;
    logic [N_CS-1:0] cs_pt = 3'b101;
    logic [N_PIN-1:0] oe_pt = 24'h01_0000;
    logic level_ld = 1'b1;
    logic strobe = 1'b0, ext_clk = 1'b0;
    logic [SUM_W-1:0] sums = '0;
    logic [N_CELL-1:0] aux = '0, clk_pt = '0, pre = '0, clr_a = '0, clr_b = '0, pol = '0, reg_sel = '1;
    logic [N_CELL-1:0] clk_ext = '0, node = '0, to_alt = '0, expand = '0;
    logic [N_GATE-1:0] gate_pt = '0, gate_stb = '0;
    logic [N_PIN-1:0] oe_eq = '0, dir = '0, dout = '0;
    logic [N_PIN-1:0] port_out, port_oe, in_bus;
    logic [N_CELL-1:0] fb;
    logic [7:0] rdat, din, got;
    logic rdoe, wr_n, rd_n;
    logic [N_SEL-1:0] sel;
    logic [N_CS-1:0] cs_d;
    int fails = 0;
    int cmp_count = 0;
    int cycles = 0;
    always #50 ref_clk = ~ref_clk;
    // a hang ends the run as a failure
    always @(posedge ref_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fails = fails + 1;
            complete_run();
        end
    end
    pml_macrocells pml_macrocells_inst (.ref_clk(ref_clk), .rst_n(rst_n), .mcu_data_in(din), .mcu_wr_n(wr_n),
        .mcu_rd_n(rd_n), .config_io_space_sel(sel), .addr_latch_strobe(strobe), .ext_clock_input(ext_clk),
        .port_pin_in(pins), .sum_terms(sums), .pt_aux(aux), .pt_clk(clk_pt), .pt_pre(pre), .pt_clr_a(clr_a),
        .pt_clr_b(clr_b), .pt_oe(oe_pt), .pt_gate(gate_pt), .pt_cs(cs_pt), .cfg_pol(pol), .cfg_reg(reg_sel),
        .cfg_ff_type({N_CELL{4'b0001}}), .cfg_clk_ext(clk_ext), .cfg_node(node), .cfg_to_alt(to_alt),
        .cfg_borrow('0), .cfg_expand(expand), .cfg_level_load(level_ld), .cfg_in_mode({N_PIN{3'b001}}),
        .cfg_gate_strobe(gate_stb), .cfg_oe_eq(oe_eq), .port_dir(dir), .port_dout(dout), .port_out_r(port_out),
        .port_oe_r(port_oe), .logic_in_bus_r(in_bus), .cell_fb_r(fb), .mcu_data_out_r(rdat), .mcu_data_oe_r(rdoe),
        .chip_sel_d_r(cs_d));
    pml_mcu_model pml_mcu_model_inst (.ref_clk(ref_clk), .rd_data(rdat), .wr_n(wr_n), .rd_n(rd_n), .sel(sel),
        .data(din));
    // one comparison, counted; a mismatch is reported at once
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] seen);
        cmp_count = cmp_count + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // pin enables with no equation, a term-driven pin and port d selects
    task automatic t_static();
        check("oe", 24'h01_FFFF, port_oe);
        check("cs", 24'(3'b101), 24'(cs_d));
        check("inbus", 24'h00_003C, in_bus);
    endtask
    // level load of the ab group, then read back
    task automatic t_level();
        pml_mcu_model_inst.read_byte(SEL_MASK_AB, got);
        check("mask", 24'(MASK_RST), 24'(got));
        pml_mcu_model_inst.write_byte(SEL_CELL_AB, 8'hA5);
        check("cells", 24'h00_00A5, 24'(fb[7:0]));
        check("pins", 24'h00_00A5, 24'(port_out[7:0]));
        pml_mcu_model_inst.read_byte(SEL_CELL_AB, got);
        check("rdcell", 24'h00_00A5, 24'(got));
    endtask
    // masked low nibble survives an edge-mode load of zero
    task automatic t_mask();
        pml_mcu_model_inst.write_byte(SEL_MASK_AB, 8'h0F);
        level_ld <= 1'b0;
        pml_mcu_model_inst.write_byte(SEL_CELL_AB, 8'h00);
        check("masked", 24'h00_0005, 24'(fb[7:0]));
        pml_mcu_model_inst.read_byte(SEL_IN_A, got);
        check("rdin", 24'h00_003C, 24'(got));
    endtask
    // term-clocked d cell through inverted polarity, then a clear; cell 0 as node hands its pin back
    task automatic t_term();
        pol[8] <= 1'b1;
        clk_pt[8] <= 1'b1;
        node[0] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("tclk", 24'h00_0105, 24'(fb));
        check("node", 24'h00_0104, 24'(port_out[15:0]));
        clr_b[8] <= 1'b1;
        repeat (3) @(posedge ref_clk);
        check("clr", 24'h00_0005, 24'(fb));
    endtask
    task automatic complete_run();
        $display("mismatches %0d of %0d compares", fails, cmp_count);
        if (fails == 0 && cmp_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
        t_static();
        t_level();
        t_mask();
        t_term();
        complete_run();
    end
endmodule
